// ==== mcd_consts.vh ====
// constants of the mechanism command decoder
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH
// ----------------------------------------
// command codes and identifier words
// ----------------------------------------
`define MCD_CODE_AUTO_SAFE 8'h5F
`define MCD_ID_AUTO_SAFE 16'hC09A
`define MCD_CODE_CAL_POWER 8'h66
`define MCD_ID_CAL_POWER 16'h00A5
`define MCD_CODE_CAL_SRC 8'h65
`define MCD_ID_CAL_SRC 16'h6006
`define MCD_CODE_CLEAR_ERR 8'h58
`define MCD_ID_CLEAR_ERR 16'hE824
`define MCD_CODE_LOG_CTRL 8'h67
`define MCD_ID_LOG_CTRL 16'h8888
// ----------------------------------------
// length words and parameter values
// ----------------------------------------
`define MCD_LEN_PARAM 16'h0002
`define MCD_LEN_NONE 16'h0000
`define MCD_PAR_ON 16'h0001
`define MCD_PAR_OFF 16'hFFFF
`define MCD_SRC_LED1 16'h0001
`define MCD_SRC_LED2 16'h0002
`define MCD_SRC_BOTH 16'h0003
`define MCD_SRC_NONE 16'h0000
// ----------------------------------------
// logging word fields
// ----------------------------------------
`define MCD_LOG_CLR_LO 1
`define MCD_LOG_CLR_HI 7
`define MCD_LOG_SET_SHUT 10
`define MCD_LOG_SET_GRA 11
`define MCD_LOG_SET_SS 12
`define MCD_LOG_SET_CMIR 13
`define MCD_LOG_SET_FMIR 14
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define MCD_TRACE_RST 7'h7F
`define MCD_CLK_MHZ 250
`define MCD_TIMEOUT_US 100
`define MCD_TIMEOUT_CYC (`MCD_TIMEOUT_US * `MCD_CLK_MHZ)
`endif

// ==== mcd_trace_buf.v ====
// one circular trace buffer
module mcd_trace_buf (
    input wire ref_clk,
    input wire rst,
    input wire enable,
    input wire clear,
    input wire wr_valid,
    input wire [15:0] wr_data,
    input wire [3:0] rd_addr,
    output reg [15:0] rd_data_r,
    output reg [4:0] fill_r
);
    reg [15:0] mem [0:15];
    reg [3:0] wr_ptr_r;
    always @(posedge ref_clk) begin
        if (rst || clear) begin
            wr_ptr_r <= 4'h0;
            fill_r <= 5'h00;
        end else if (enable && wr_valid) begin
            wr_ptr_r <= wr_ptr_r + 4'h1;
            if (fill_r != 5'h10) begin
                fill_r <= fill_r + 5'h01;
            end
        end
    end
    always @(posedge ref_clk) begin
        if (enable && wr_valid && !clear) begin
            mem[wr_ptr_r] <= wr_data;
        end
        // entries past the fill level read as erased
        rd_data_r <= ({1'b0, rd_addr} < fill_r) ? mem[rd_addr] : 16'h0000;
    end
endmodule

// ==== mcd_decoder.v ====
// command word decoder for the mechanism controller
//
// How it works
// - auto-safe enable runs the health monitor
// - auto-safe off at reset; 0001 on, FFFF off
// - cal power relay: 0001 closed, FFFF open
// - cal source word selects LED one, two, both
// - error clear zeroes both error status words
// - logging command takes one parameter word
// - clear bit erases matching trace buffer
// - set bit enables buffer, zero disables; stepper buffers enable only with bits eleven to fourteen all set
// - trace buffers are circular, overwrite oldest
// - clear bits one to seven, others spare
// - bits ten to twelve enable shutter, grating, slit
// - stepper trace off stops all stepper logging
// - shutter disable affects only shutter trace
// - bits thirteen, fourteen enable mirror traces
// - all trace buffers enabled after reset
`include "mcd_consts.vh"
module mcd_decoder #(
    parameter TIMEOUT_CYC = `MCD_TIMEOUT_CYC
) (
    input wire ref_clk,
    input wire rst,
    input wire cmd_valid,
    input wire [15:0] cmd_word,
    input wire [15:0] err_set_high,
    input wire [15:0] err_set_low,
    input wire limit_fault,
    input wire trace_wr_valid,
    input wire [15:0] trace_wr_data,
    input wire [2:0] trace_rd_sel,
    input wire [3:0] trace_rd_addr,
    output reg cmd_ack_r,
    output reg cmd_nack_r,
    output reg auto_safe_en_r,
    output reg safe_action_r,
    output reg cal_relay_closed_r,
    output reg [1:0] calib_source_status_r,
    output reg [15:0] error_status_high_word_r,
    output reg [15:0] error_status_low_word_r,
    output reg [6:0] trace_en_r,
    output reg [15:0] trace_rd_data_r
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_CODE = 2'd0;
    localparam ST_ID = 2'd1;
    localparam ST_LEN = 2'd2;
    localparam ST_PAR = 2'd3;
    localparam [31:0] TO_LAST = TIMEOUT_CYC - 1;

    reg [1:0] state_r;
    reg [7:0] code_r;
    reg [15:0] id_r;
    reg [15:0] len_r;
    reg [31:0] timer_r;
    reg [6:0] trace_clr_r;
    reg [6:0] trace_en_nxt;
    reg known;
    reg needs_par;
    reg par_ok;
    wire [15:0] buf_rd [0:6];

    // ----------------------------------------
    // pair and parameter checks
    // ----------------------------------------
    always @* begin
        known = 1'b1;
        needs_par = 1'b1;
        case (code_r)
            `MCD_CODE_AUTO_SAFE: known = (id_r == `MCD_ID_AUTO_SAFE);
            `MCD_CODE_CAL_POWER: known = (id_r == `MCD_ID_CAL_POWER);
            `MCD_CODE_CAL_SRC: known = (id_r == `MCD_ID_CAL_SRC);
            `MCD_CODE_LOG_CTRL: known = (id_r == `MCD_ID_LOG_CTRL);
            `MCD_CODE_CLEAR_ERR: begin
                known = (id_r == `MCD_ID_CLEAR_ERR);
                needs_par = 1'b0;
            end
            default: known = 1'b0;
        endcase
    end

    always @* begin
        case (code_r)
            `MCD_CODE_AUTO_SAFE, `MCD_CODE_CAL_POWER: par_ok = (cmd_word == `MCD_PAR_ON) ||
                (cmd_word == `MCD_PAR_OFF);
            `MCD_CODE_CAL_SRC: par_ok = (cmd_word[15:2] == 14'h0000);
            default: par_ok = 1'b1;
        endcase
    end

    // ----------------------------------------
    // new trace enables from a logging word
    // ----------------------------------------
    // index: 0 power, 1 shutter, 2 grating, 3 slit, 4 coarse, 5 fine, 6 command
    always @* begin
        trace_en_nxt = trace_en_r;
        trace_en_nxt[1] = cmd_word[`MCD_LOG_SET_SHUT];
        if (!cmd_word[`MCD_LOG_SET_GRA] || !cmd_word[`MCD_LOG_SET_SS] || !cmd_word[`MCD_LOG_SET_CMIR] ||
            !cmd_word[`MCD_LOG_SET_FMIR]) begin
            trace_en_nxt[5:2] = 4'h0;
        end else begin
            trace_en_nxt[5:2] = 4'hF;
        end
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_CODE;
            code_r <= 8'h00;
            id_r <= 16'h0000;
            len_r <= 16'h0000;
            timer_r <= 32'h00000000;
            cmd_ack_r <= 1'b0;
            cmd_nack_r <= 1'b0;
            auto_safe_en_r <= 1'b0;
            cal_relay_closed_r <= 1'b1;
            calib_source_status_r <= 2'h0;
            trace_en_r <= `MCD_TRACE_RST;
            trace_clr_r <= 7'h00;
        end else begin
            cmd_ack_r <= 1'b0;
            cmd_nack_r <= 1'b0;
            trace_clr_r <= 7'h00;
            if (state_r != ST_CODE) begin
                timer_r <= timer_r + 32'h00000001;
            end
            if (state_r != ST_CODE && !cmd_valid && timer_r >= TO_LAST) begin
                state_r <= ST_CODE;
            end else if (cmd_valid) begin
                timer_r <= 32'h00000000;
                case (state_r)
                    ST_CODE: begin
                        code_r <= cmd_word[7:0];
                        state_r <= ST_ID;
                    end
                    ST_ID: begin
                        id_r <= cmd_word;
                        state_r <= ST_LEN;
                    end
                    ST_LEN: begin
                        len_r <= cmd_word;
                        if (!known || (needs_par && cmd_word != `MCD_LEN_PARAM) ||
                            (!needs_par && cmd_word != `MCD_LEN_NONE)) begin
                            cmd_nack_r <= 1'b1;
                            state_r <= ST_CODE;
                        end else if (!needs_par) begin
                            cmd_ack_r <= 1'b1;
                            state_r <= ST_CODE;
                        end else begin
                            state_r <= ST_PAR;
                        end
                    end
                    ST_PAR: begin
                        state_r <= ST_CODE;
                        if (!par_ok) begin
                            cmd_nack_r <= 1'b1;
                        end else begin
                            cmd_ack_r <= 1'b1;
                            case (code_r)
                                `MCD_CODE_AUTO_SAFE: auto_safe_en_r <= (cmd_word == `MCD_PAR_ON);
                                `MCD_CODE_CAL_POWER: cal_relay_closed_r <= (cmd_word == `MCD_PAR_ON);
                                `MCD_CODE_CAL_SRC: calib_source_status_r <= cmd_word[1:0];
                                `MCD_CODE_LOG_CTRL: begin
                                    trace_en_r <= trace_en_nxt;
                                    trace_clr_r <= cmd_word[`MCD_LOG_CLR_HI:`MCD_LOG_CLR_LO];
                                end
                                default: cmd_ack_r <= 1'b1;
                            endcase
                        end
                    end
                    default: state_r <= ST_CODE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // error words and health monitor
    // ----------------------------------------
    wire clr_err = cmd_valid && state_r == ST_LEN && known && !needs_par && cmd_word == `MCD_LEN_NONE;
    always @(posedge ref_clk) begin
        if (rst) begin
            error_status_high_word_r <= 16'h0000;
            error_status_low_word_r <= 16'h0000;
            safe_action_r <= 1'b0;
        end else begin
            // new errors win over the clear
            error_status_high_word_r <= (clr_err ? 16'h0000 : error_status_high_word_r) | err_set_high;
            error_status_low_word_r <= (clr_err ? 16'h0000 : error_status_low_word_r) | err_set_low;
            safe_action_r <= auto_safe_en_r && limit_fault;
        end
    end

    // ----------------------------------------
    // trace buffers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : tb
            mcd_trace_buf u_buf (
                .ref_clk(ref_clk),
                .rst(rst),
                .enable(trace_en_r[g]),
                .clear(trace_clr_r[g]),
                .wr_valid(trace_wr_valid),
                .wr_data(trace_wr_data),
                .rd_addr(trace_rd_addr),
                .rd_data_r(buf_rd[g]),
                .fill_r()
            );
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (rst) begin
            trace_rd_data_r <= 16'h0000;
        end else begin
            trace_rd_data_r <= (trace_rd_sel == 3'h7) ? 16'h0000 : buf_rd[trace_rd_sel];
        end
    end
endmodule

// ==== mcd_decoder_props.sv ====
// assertion checker of the mechanism command decoder
module mcd_decoder_props (
    input logic ref_clk,
    input logic rst,
    input logic cmd_valid,
    input logic [15:0] cmd_word,
    input logic limit_fault,
    input logic cmd_ack_r,
    input logic cmd_nack_r,
    input logic auto_safe_en_r,
    input logic safe_action_r,
    input logic cal_relay_closed_r,
    input logic [6:0] trace_en_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------
    // command steps
    // ----------------
    sequence s_src_head; cmd_valid && cmd_word[7:0] == 8'h65 ##1 cmd_valid && cmd_word == 16'h6006; endsequence
    sequence s_bad_len; s_src_head ##1 cmd_valid && cmd_word != 16'h0002; endsequence
    // ----------------
    // properties
    // ----------------
    property p_resp; cmd_ack_r || cmd_nack_r |=> !cmd_ack_r && !cmd_nack_r; endproperty
    a_resp: assert property (p_resp) else $error("response longer than one cycle");
    property p_bad_len; s_bad_len |=> cmd_nack_r; endproperty
    a_bad_len: assert property (p_bad_len) else $error("wrong length not rejected");
    property p_safe; 1'b1 |=> safe_action_r == $past(auto_safe_en_r && limit_fault); endproperty
    a_safe: assert property (p_safe) else $error("safe action wrong");
    property p_safe_cmd; $changed(auto_safe_en_r) |-> cmd_ack_r; endproperty
    a_safe_cmd: assert property (p_safe_cmd) else $error("auto-safe changed without command");
    property p_relay_cmd; $changed(cal_relay_closed_r) |-> cmd_ack_r; endproperty
    a_relay_cmd: assert property (p_relay_cmd) else $error("relay changed without command");
    property p_trace_cmd; $changed(trace_en_r) |-> cmd_ack_r; endproperty
    a_trace_cmd: assert property (p_trace_cmd) else $error("traces changed without command");
    property p_step; trace_en_r[5:2] == 4'hF || trace_en_r[5:2] == 4'h0; endproperty
    a_step: assert property (p_step) else $error("stepper traces split");
    property p_keep; trace_en_r[0] && trace_en_r[6]; endproperty
    a_keep: assert property (p_keep) else $error("power or command trace disabled");
    property p_reset; $fell(rst) |-> trace_en_r == 7'h7F && !auto_safe_en_r && cal_relay_closed_r; endproperty
    a_reset: assert property (p_reset) else $error("wrong state after reset");
endmodule
bind mcd_decoder mcd_decoder_props u_props (.*);

// ==== mcd_icu_model.sv ====
// command sender model of the instrument control unit
module mcd_icu_model (
    input logic ref_clk,
    output logic cmd_valid,
    output logic [15:0] cmd_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 16'h0000;
    end
    task automatic put(input logic [15:0] w);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
    endtask
    // released word lines toggle every cycle
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            cmd_valid <= 1'b0;
            cmd_word <= ~cmd_word;
        end
    endtask
    task automatic send(input logic [7:0] c, input logic [15:0] i, l, p, input int np, gap);
        put({8'h00, c});
        idle(gap);
        put(i);
        idle(gap);
        put(l);
        if (np > 0) begin
            idle(gap);
            put(p);
        end
        idle(1);
    endtask
    // logging shutdown after a rejected move, traces kept for dump
    task automatic log_off;
        send(8'h67, 16'h8888, 16'h0002, 16'h0000, 1, 0);
    endtask
endmodule

// ==== mechanism_command_decoder_bench.sv ====
// self-checking bench of the mechanism command decoder
module mechanism_command_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] c; logic [15:0] i, l, p; int n; logic [2:0] f; logic [1:0] q; logic [6:0] t;} mcd_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic limit_fault = 1'b0;
    logic [15:0] err_set_high = 16'h0000;
    logic [15:0] err_set_low = 16'h0000;
    logic twv = 1'b0;
    logic [15:0] twd = 16'h0000;
    logic [2:0] trs = 3'h0;
    logic [15:0] trd;
    logic cmd_valid, ack, nack, safe, act, relay, a, nk;
    logic [15:0] cmd_word, eh, el;
    logic [1:0] src;
    logic [6:0] ten;
    int failures = 0;
    int checked = 0;
    // ----------------
    // rows: code, id, length, param, count, ack/safe/relay, source, traces
    // ----------------
    mcd_row_t rows [15] = '{
        '{8'h5F, 16'hC09A, 16'h0002, 16'h0001, 1, 3'h7, 2'h0, 7'h7F},
        '{8'h5F, 16'hC09A, 16'h0002, 16'hFFFF, 1, 3'h5, 2'h0, 7'h7F},
        '{8'h66, 16'h00A5, 16'h0002, 16'hFFFF, 1, 3'h4, 2'h0, 7'h7F},
        '{8'h66, 16'h00A5, 16'h0002, 16'h0001, 1, 3'h5, 2'h0, 7'h7F},
        '{8'h65, 16'h6006, 16'h0002, 16'h0001, 1, 3'h5, 2'h1, 7'h7F},
        '{8'h65, 16'h6006, 16'h0002, 16'h0002, 1, 3'h5, 2'h2, 7'h7F},
        '{8'h65, 16'h6006, 16'h0002, 16'h0003, 1, 3'h5, 2'h3, 7'h7F},
        '{8'h65, 16'h6006, 16'h0002, 16'h0004, 1, 3'h1, 2'h3, 7'h7F},
        '{8'h65, 16'h6006, 16'h0002, 16'h0000, 1, 3'h5, 2'h0, 7'h7F},
        '{8'h66, 16'h6006, 16'h0002, 16'h0001, 0, 3'h1, 2'h0, 7'h7F},
        '{8'h65, 16'h6006, 16'h0003, 16'h0001, 0, 3'h1, 2'h0, 7'h7F},
        '{8'h67, 16'h8888, 16'h0002, 16'h7800, 1, 3'h5, 2'h0, 7'h7D},
        '{8'h67, 16'h8888, 16'h0002, 16'h3C00, 1, 3'h5, 2'h0, 7'h43},
        '{8'h67, 16'h8888, 16'h0002, 16'h7CFE, 1, 3'h5, 2'h0, 7'h7F},
        '{8'h5F, 16'hC09A, 16'h0002, 16'h0001, 1, 3'h7, 2'h0, 7'h7F}};
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    mcd_icu_model icu (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
    mcd_decoder #(.TIMEOUT_CYC(20)) dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .err_set_high(err_set_high), .err_set_low(err_set_low), .limit_fault(limit_fault),
        .trace_wr_valid(twv), .trace_wr_data(twd), .trace_rd_sel(trs), .trace_rd_addr(4'h0),
        .cmd_ack_r(ack), .cmd_nack_r(nack), .auto_safe_en_r(safe), .safe_action_r(act),
        .cal_relay_closed_r(relay), .calib_source_status_r(src), .error_status_high_word_r(eh),
        .error_status_low_word_r(el), .trace_en_r(ten), .trace_rd_data_r(trd));
    // ----------------
    // checking tasks
    // ----------------
    task automatic end_of_test;
        if (failures == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic watch(input int n);
        a = 1'b0;
        nk = 1'b0;
        repeat (n) begin
            @(negedge ref_clk);
            if (ack === 1'b1 || nack === 1'b1) begin
                a = ack;
                nk = nack;
                break;
            end
        end
    endtask
    task automatic run(input int j, gap);
        icu.send(rows[j].c, rows[j].i, rows[j].l, rows[j].p, rows[j].n, gap);
        watch(6);
        if (a !== 1'b1 && nk !== 1'b1) begin
            failures++;
            end_of_test();
        end
        chk("ack", rows[j].f[2], a);
        chk("nack", !rows[j].f[2], nk);
        chk("safe", rows[j].f[1], safe);
        chk("relay", rows[j].f[0], relay);
        chk("source", rows[j].q, src);
        chk("traces", rows[j].t, ten);
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk("traces", 7'h7F, ten);
        chk("safe", 1'b0, safe);
        chk("relay", 1'b1, relay);
        chk("source", 2'h0, src);
        for (int j = 0; j < 15; j++) begin
            run(j, 0);
        end
        @(posedge ref_clk);
        limit_fault <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("action", 1'b1, act);
        run(1, 15);
        @(negedge ref_clk);
        chk("action", 1'b0, act);
        icu.log_off();
        watch(6);
        chk("traces", 7'h41, ten);
        @(posedge ref_clk);
        err_set_high <= 16'h8001;
        err_set_low <= 16'h0100;
        @(posedge ref_clk);
        err_set_high <= 16'h0000;
        err_set_low <= 16'h0000;
        @(negedge ref_clk);
        chk("err_high", 16'h8001, eh);
        chk("err_low", 16'h0100, el);
        icu.send(8'h58, 16'hE824, 16'h0000, 16'h0000, 0, 0);
        watch(6);
        chk("ack", 1'b1, a);
        chk("err_high", 16'h0000, eh);
        chk("err_low", 16'h0000, el);
        icu.send(8'h65, 16'h6006, 16'h0002, 16'h0003, 1, 25);
        watch(30);
        chk("response", 1'b0, a | nk);
        chk("source", 2'h0, src);
        icu.send(8'h67, 16'h8888, 16'h0002, 16'h7C00, 1, 0);
        watch(6);
        chk("traces", 7'h7F, ten);
        @(posedge ref_clk);
        twv <= 1'b1;
        twd <= 16'hA5A5;
        @(posedge ref_clk);
        twv <= 1'b0;
        trs <= 3'h1;
        repeat (3) @(negedge ref_clk);
        chk("trace_read", 16'hA5A5, trd);
        icu.send(8'h67, 16'h8888, 16'h0002, 16'h7C04, 1, 0);
        watch(6);
        repeat (3) @(negedge ref_clk);
        chk("trace_read", 16'h0000, trd);
        @(posedge ref_clk);
        trs <= 3'h0;
        repeat (3) @(negedge ref_clk);
        chk("trace_read", 16'hA5A5, trd);
        end_of_test();
    end
endmodule
